// ===== rtl/sfpi_flash_if.sv
// Serial pin interface of a small serial flash, device side.
//
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module sfpi_flash_if #(
	parameter int unsigned PROG_CYCLES = sfpi_pkg::PROG_CYCLES
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_b,
	// Serial pins
	input  wire logic chipSelN,
	input  wire logic serClk,
	input  wire logic laneZeroIn,
	output logic      laneZeroOut,
	output logic      laneZeroOeN,
	input  wire logic laneOneIn,
	output logic      laneOneOut,
	output logic      laneOneOeN,
	// Control pins
	input  wire logic writeProtN,
	input  wire logic pauseN,
	// Device state
	output logic      standby,
	output logic      busy,
	output logic      progFail
);

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [5:0] syncA_q;
	logic [5:0] syncB_q;
	logic [1:0] prev_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			syncA_q <= 6'h3F;
			syncB_q <= 6'h3F;
			prev_q  <= 2'h3;
		end else begin
			syncA_q <= {pauseN, writeProtN, laneOneIn, laneZeroIn, serClk, chipSelN};
			syncB_q <= syncA_q;
			prev_q  <= syncB_q[1:0];
		end
	end

	logic sel, csFall, csRise, sckRise, sckFall, pause_q, live, rise, fall;
	assign sel     = !syncB_q[0];
	assign csFall  = sel && prev_q[0];
	assign csRise  = !sel && !prev_q[0];
	assign sckRise = syncB_q[1] && !prev_q[1];
	assign sckFall = !syncB_q[1] && prev_q[1];
	assign live    = sel && !pause_q;
	assign rise    = sckRise && live;
	assign fall    = sckFall && live;

	// Inside a frame a pause only begins or ends while the clock is low, so a half edge is never lost; deselect also ends it.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pause_q <= 1'b0;
		end else if (!sel) begin
			pause_q <= 1'b0;
		end else if (!syncB_q[1]) begin
			pause_q <= !syncB_q[5];
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [18:0] mapAddr(input logic [23:0] a, input logic otp);
		mapAddr = otp ? (sfpi_pkg::OTP_BASE | {12'h000, a[6:0]}) : {1'b0, a[17:0]};
	endfunction

	function automatic logic [17:0] eraseSpan(input logic [7:0] op);
		case (op)
			sfpi_pkg::OP_ERASE_PG:  eraseSpan = sfpi_pkg::SPAN_PAGE;
			sfpi_pkg::OP_ERASE_4K:  eraseSpan = sfpi_pkg::SPAN_4K;
			sfpi_pkg::OP_ERASE_32K: eraseSpan = sfpi_pkg::SPAN_32K;
			sfpi_pkg::OP_ERASE_64K: eraseSpan = sfpi_pkg::SPAN_64K;
			default:                eraseSpan = sfpi_pkg::SPAN_CHIP;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Shifting and command decode state
	// ----------------------------------------------------------------
	sfpi_pkg::sfpi_phase_e  phase_q;
	sfpi_pkg::sfpi_engine_e eng_q;
	logic [7:0]  sh_q, shD, cmd_q, outSh_q, statByte, rdData, newByte, wrData_q;
	logic [2:0]  bitCnt_q, cntD, outLeft_q;
	logic [1:0]  byteCnt_q;
	logic [23:0] addr_q;
	logic [18:0] wrAddr_q, eAddr_q, memWrAddr;
	logic [17:0] eLeft_q;
	logic [19:0] waitCnt_q;
	logic        dualIn, dualOut, byteDone, otpSel, pendErase_q, pendProg_q;
	logic        wrEn_q, fail_q, otpLock_q, drive_q, dual_q;
	logic        isRead, isProg, isErase, memWrEn;

	assign dualIn   = (phase_q == sfpi_pkg::PH_DIN) && (cmd_q == sfpi_pkg::OP_PROG_DUAL);
	assign dualOut  = (cmd_q == sfpi_pkg::OP_READ_DUAL);
	assign shD      = dualIn ? {sh_q[5:0], syncB_q[3], syncB_q[2]} : {sh_q[6:0], syncB_q[2]};
	assign cntD     = bitCnt_q + (dualIn ? 3'h2 : 3'h1);
	assign byteDone = rise && (cntD == 3'h0);
	assign otpSel   = (cmd_q == sfpi_pkg::OP_OTP_READ) || (cmd_q == sfpi_pkg::OP_OTP_PROG);
	assign isRead   = (shD == sfpi_pkg::OP_READ) || (shD == sfpi_pkg::OP_READ_DUAL)
	               || (shD == sfpi_pkg::OP_OTP_READ);
	assign isProg   = (shD == sfpi_pkg::OP_PROG) || (shD == sfpi_pkg::OP_PROG_DUAL)
	               || (shD == sfpi_pkg::OP_OTP_PROG);
	assign isErase  = (shD == sfpi_pkg::OP_ERASE_PG) || (shD == sfpi_pkg::OP_ERASE_4K)
	               || (shD == sfpi_pkg::OP_ERASE_32K) || (shD == sfpi_pkg::OP_ERASE_64K);
	assign newByte  = rdData & shD;

	always_comb begin
		statByte = 8'h00;
		statByte[sfpi_pkg::STAT_BUSY_BIT] = busy;
		statByte[sfpi_pkg::STAT_FAIL_BIT] = fail_q;
	end

	// ----------------------------------------------------------------
	// Command, address and write-data phases
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			phase_q     <= sfpi_pkg::PH_IDLE;
			sh_q        <= 8'h00;
			cmd_q       <= 8'h00;
			bitCnt_q    <= 3'h0;
			byteCnt_q   <= 2'h0;
			addr_q      <= 24'h000000;
			pendErase_q <= 1'b0;
			pendProg_q  <= 1'b0;
			wrEn_q      <= 1'b0;
			wrAddr_q    <= 19'h00000;
			wrData_q    <= 8'h00;
		end else begin
			wrEn_q <= 1'b0;
			if (!sel) begin
				phase_q <= sfpi_pkg::PH_IDLE;
				if (csRise) begin
					pendErase_q <= 1'b0;
					pendProg_q  <= 1'b0;
				end
			end else if (csFall) begin
				phase_q   <= sfpi_pkg::PH_CMD;
				bitCnt_q  <= 3'h0;
				byteCnt_q <= 2'h0;
			end else if (rise && (phase_q == sfpi_pkg::PH_CMD || phase_q == sfpi_pkg::PH_ADDR
			                      || phase_q == sfpi_pkg::PH_DIN)) begin
				sh_q     <= shD;
				bitCnt_q <= cntD;
				if (byteDone) begin
					case (phase_q)
						sfpi_pkg::PH_CMD: begin
							cmd_q   <= shD;
							phase_q <= sfpi_pkg::PH_SKIP;
							if (shD == sfpi_pkg::OP_STATUS) begin
								phase_q <= sfpi_pkg::PH_DOUT;
							end else if (!busy && (isRead || isProg || isErase)) begin
								phase_q <= sfpi_pkg::PH_ADDR;
							end else if (!busy && shD == sfpi_pkg::OP_ERASE_ALL && syncB_q[4]) begin
								pendErase_q <= 1'b1;
							end
						end
						sfpi_pkg::PH_ADDR: begin
							addr_q    <= {addr_q[15:0], shD};
							byteCnt_q <= byteCnt_q + 2'h1;
							if (byteCnt_q == 2'h2) begin
								if (cmd_q == sfpi_pkg::OP_READ || cmd_q == sfpi_pkg::OP_READ_DUAL
								    || cmd_q == sfpi_pkg::OP_OTP_READ) begin
									phase_q <= sfpi_pkg::PH_DOUT;
								end else if (!syncB_q[4]) begin
									phase_q <= sfpi_pkg::PH_SKIP;
								end else if (cmd_q == sfpi_pkg::OP_PROG || cmd_q == sfpi_pkg::OP_PROG_DUAL
								             || cmd_q == sfpi_pkg::OP_OTP_PROG) begin
									phase_q <= sfpi_pkg::PH_DIN;
								end else begin
									phase_q     <= sfpi_pkg::PH_SKIP;
									pendErase_q <= 1'b1;
								end
							end
						end
						sfpi_pkg::PH_DIN: begin
							// The address only wraps inside its page, so long bursts rewrite the page.
							addr_q     <= {addr_q[23:8], addr_q[7:0] + 8'h01};
							pendProg_q <= 1'b1;
							wrAddr_q   <= mapAddr(addr_q, otpSel);
							wrData_q   <= newByte;
							wrEn_q     <= !(otpSel && (otpLock_q || addr_q[6:0] < sfpi_pkg::OTP_USER_LO));
						end
						default: begin
							phase_q <= sfpi_pkg::PH_SKIP;
						end
					endcase
				end
			end else if (fall && phase_q == sfpi_pkg::PH_DOUT && outLeft_q == 3'h0
			             && cmd_q != sfpi_pkg::OP_STATUS) begin
				addr_q <= addr_q + 24'h000001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Failure flag and one-time lock
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			fail_q    <= 1'b0;
			otpLock_q <= 1'b0;
		end else begin
			if (byteDone && phase_q == sfpi_pkg::PH_CMD && !busy && (isProg || isErase
			    || shD == sfpi_pkg::OP_ERASE_ALL)) begin
				fail_q <= 1'b0;
			end
			// A bit that is asked to go from 0 to 1, or a locked OTP byte, counts as failure.
			if (byteDone && phase_q == sfpi_pkg::PH_DIN && (newByte != shD || (otpSel
			    && (otpLock_q || addr_q[6:0] < sfpi_pkg::OTP_USER_LO)))) begin
				fail_q <= 1'b1;
			end
			if (csRise && pendProg_q && cmd_q == sfpi_pkg::OP_OTP_PROG) begin
				otpLock_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Output shifter
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			outSh_q     <= 8'h00;
			outLeft_q   <= 3'h0;
			drive_q     <= 1'b0;
			dual_q      <= 1'b0;
			laneOneOut  <= 1'b0;
			laneZeroOut <= 1'b0;
		end else if (!sel) begin
			drive_q   <= 1'b0;
			dual_q    <= 1'b0;
			outLeft_q <= 3'h0;
		end else if (fall && phase_q == sfpi_pkg::PH_DOUT) begin
			drive_q <= 1'b1;
			dual_q  <= dualOut;
			if (outLeft_q == 3'h0) begin
				if (dualOut) begin
					laneOneOut  <= rdData[7];
					laneZeroOut <= rdData[6];
					outSh_q     <= {rdData[5:0], 2'h0};
					outLeft_q   <= 3'h3;
				end else begin
					laneOneOut <= (cmd_q == sfpi_pkg::OP_STATUS) ? statByte[7] : rdData[7];
					outSh_q    <= (cmd_q == sfpi_pkg::OP_STATUS) ? {statByte[6:0], 1'b0}
					                                             : {rdData[6:0], 1'b0};
					outLeft_q  <= 3'h7;
				end
			end else begin
				laneOneOut  <= outSh_q[7];
				laneZeroOut <= outSh_q[6];
				outSh_q     <= dual_q ? {outSh_q[5:0], 2'h0} : {outSh_q[6:0], 1'b0};
				outLeft_q   <= outLeft_q - 3'h1;
			end
		end
	end

	assign laneOneOeN  = !(drive_q && !pause_q);
	assign laneZeroOeN = !(drive_q && dual_q && !pause_q);

	// ----------------------------------------------------------------
	// Self-timed engine
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			eng_q     <= sfpi_pkg::EN_READY;
			eAddr_q   <= 19'h00000;
			eLeft_q   <= 18'h00000;
			waitCnt_q <= 20'h00000;
		end else begin
			case (eng_q)
				sfpi_pkg::EN_READY: begin
					if (csRise && pendErase_q) begin
						eng_q   <= sfpi_pkg::EN_ERASE;
						eAddr_q <= {1'b0, addr_q[17:0] & ~eraseSpan(cmd_q)};
						eLeft_q <= eraseSpan(cmd_q);
					end else if (csRise && pendProg_q) begin
						eng_q     <= sfpi_pkg::EN_WAIT;
						waitCnt_q <= 20'(PROG_CYCLES - 1);
					end
				end
				sfpi_pkg::EN_ERASE: begin
					eAddr_q <= eAddr_q + 19'h00001;
					eLeft_q <= eLeft_q - 18'h00001;
					if (eLeft_q == 18'h00000) begin
						eng_q <= sfpi_pkg::EN_READY;
					end
				end
				sfpi_pkg::EN_WAIT: begin
					waitCnt_q <= waitCnt_q - 20'h00001;
					if (waitCnt_q == 20'h00000) begin
						eng_q <= sfpi_pkg::EN_READY;
					end
				end
				default: begin
					eng_q <= sfpi_pkg::EN_READY;
				end
			endcase
		end
	end

	assign busy     = (eng_q != sfpi_pkg::EN_READY);
	assign standby  = !sel && !busy;
	assign progFail = fail_q;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	assign memWrEn   = (eng_q == sfpi_pkg::EN_ERASE) || wrEn_q;
	assign memWrAddr = (eng_q == sfpi_pkg::EN_ERASE) ? eAddr_q : wrAddr_q;

	sfpi_byte_mem uMem (
		.mclk   (mclk),
		.wrEn   (memWrEn),
		.wrAddr (memWrAddr),
		.wrData ((eng_q == sfpi_pkg::EN_ERASE) ? sfpi_pkg::ERASED_BYTE : wrData_q),
		.rdAddr (mapAddr(addr_q, otpSel)),
		.rdData (rdData)
	);

endmodule

// ===== rtl/sfpi_pkg.sv
// Shared constants for the serial flash pin interface.
package sfpi_pkg;

	// ----------------------------------------------------------------
	// Storage layout
	// ----------------------------------------------------------------
	localparam int unsigned MEM_ADDR_W   = 19;
	localparam int unsigned FLASH_ADDR_W = 18;
	localparam logic [18:0] OTP_BASE     = 19'h40000;
	localparam logic [6:0]  OTP_USER_LO  = 7'h40;
	localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

	// ----------------------------------------------------------------
	// Erase spans, stored as size minus one
	// ----------------------------------------------------------------
	localparam logic [17:0] SPAN_PAGE = 18'h000FF;
	localparam logic [17:0] SPAN_4K   = 18'h00FFF;
	localparam logic [17:0] SPAN_32K  = 18'h07FFF;
	localparam logic [17:0] SPAN_64K  = 18'h0FFFF;
	localparam logic [17:0] SPAN_CHIP = 18'h3FFFF;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_READ      = 8'h03;
	localparam logic [7:0] OP_READ_DUAL = 8'h3B;
	localparam logic [7:0] OP_PROG      = 8'h02;
	localparam logic [7:0] OP_PROG_DUAL = 8'hA2;
	localparam logic [7:0] OP_ERASE_PG  = 8'h81;
	localparam logic [7:0] OP_ERASE_4K  = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hD8;
	localparam logic [7:0] OP_ERASE_ALL = 8'hC7;
	localparam logic [7:0] OP_STATUS    = 8'h05;
	localparam logic [7:0] OP_OTP_READ  = 8'h4B;
	localparam logic [7:0] OP_OTP_PROG  = 8'h9B;

	// ----------------------------------------------------------------
	// Status byte fields
	// ----------------------------------------------------------------
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_FAIL_BIT = 5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned MCLK_PERIOD_NS = 50;
	localparam int unsigned PROG_TIME_NS   = 2000000;
	localparam int unsigned PROG_CYCLES    = PROG_TIME_NS / MCLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DIN, PH_DOUT, PH_SKIP} sfpi_phase_e;
	typedef enum logic [1:0] {EN_READY, EN_ERASE, EN_WAIT} sfpi_engine_e;

endpackage

// ===== rtl/sfpi_byte_mem.sv
// Byte-wide storage for the flash array and the one-time-programmable area.
`timescale 1ns/1ps
module sfpi_byte_mem (
	// Clock
	input  wire logic                             mclk,
	// Write side
	input  wire logic                             wrEn,
	input  wire logic [sfpi_pkg::MEM_ADDR_W-1:0]  wrAddr,
	input  wire logic [7:0]                       wrData,
	// Read side
	input  wire logic [sfpi_pkg::MEM_ADDR_W-1:0]  rdAddr,
	output logic      [7:0]                       rdData
);

	logic [7:0] store [2**sfpi_pkg::MEM_ADDR_W];

	// No reset: the array holds its contents like real cells would.
	always_ff @(posedge mclk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
		rdData <= store[rdAddr];
	end

endmodule

// ===== verif/sfpi_flash_if_checker.sv
// Pin-level assertions for the serial flash interface.
`timescale 1ns/1ps
module sfpi_flash_if_checker #(
	parameter int unsigned PROG_CYCLES = 20
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Serial and control pins
	input wire logic chipSelN,
	input wire logic serClk,
	input wire logic laneZeroOut,
	input wire logic laneZeroOeN,
	input wire logic laneOneOut,
	input wire logic laneOneOeN,
	input wire logic writeProtN,
	input wire logic pauseN,
	// Device state
	input wire logic standby,
	input wire logic busy,
	input wire logic progFail
);
	logic [18:0] busyLen_q;

	// Length of the running busy stretch, so that its end can be judged.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busyLen_q <= 19'h00000;
		end else begin
			busyLen_q <= busy ? busyLen_q + 19'h00001 : 19'h00000;
		end
	end

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_float_deselect: assert property (chipSelN [*6] |-> laneOneOeN && laneZeroOeN)
		else $error("output enabled while deselected");
	a_idle_standby: assert property (chipSelN [*6] ##0 !busy |-> standby)
		else $error("no standby while idle");
	a_select_active: assert property ((!chipSelN) [*5] |-> !standby)
		else $error("standby while selected");
	a_standby_busy: assert property ($rose(busy) |-> chipSelN && !standby)
		else $error("self-timed work began inside a frame");
	a_busy_length: assert property ($fell(busy) |-> busyLen_q inside {PROG_CYCLES,
		19'h00100, 19'h01000, 19'h08000, 19'h10000, 19'h40000})
		else $error("busy stretch of wrong length");
	a_shift_on_fall: assert property (!chipSelN && !laneOneOeN && serClk && $past(serClk, 4)
		|-> $stable(laneOneOut) && ($stable(laneZeroOut) || laneZeroOeN))
		else $error("output moved while serial clock high");
	a_dual_pair: assert property (!laneZeroOeN && $changed(laneZeroOut) |-> !serClk && !laneOneOeN)
		else $error("lane zero moved outside a low clock phase");
	a_lane_turn: assert property ($fell(laneZeroOeN) |-> !chipSelN && pauseN)
		else $error("lane zero turned outside a frame");
	a_pause_float: assert property ((!pauseN) [*6] |-> laneOneOeN && laneZeroOeN)
		else $error("output enabled during pause");
	a_fail_sticky: assert property (chipSelN [*8] |-> $stable(progFail))
		else $error("failure flag moved while idle");
	a_wp_blocks: assert property ((!writeProtN) [*8] |-> !$rose(busy))
		else $error("work started while protected");
endmodule

bind sfpi_flash_if sfpi_flash_if_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (
	.mclk, .rst_b, .chipSelN, .serClk, .laneZeroOut, .laneZeroOeN, .laneOneOut,
	.laneOneOeN, .writeProtN, .pauseN, .standby, .busy, .progFail
);

// ===== verif/sfpi_host_model.sv
// Host model: an SPI master that works the flash pins in mode 0 or mode 3.
`timescale 1ns/1ps
module sfpi_host_model (
	// Clock
	input  wire logic mclk,
	// Pins towards the device
	output logic      chipSelN,
	output logic      serClk,
	output logic      laneZeroIn,
	output logic      laneOneIn,
	output logic      pauseN,
	// Pins from the device
	input  wire logic laneZeroOut,
	input  wire logic laneZeroOeN,
	input  wire logic laneOneOut,
	input  wire logic laneOneOeN
);
	logic       hostZero;
	logic       hostOne;
	logic       modeThree;
	logic [1:0] pauseSeen;
	int         holdAt;

	// Whoever holds the enable owns the wire; the device sees its own drive.
	assign laneZeroIn = laneZeroOeN ? hostZero : laneZeroOut;
	assign laneOneIn  = laneOneOeN ? hostOne : laneOneOut;

	initial begin
		chipSelN  = 1'b1;
		serClk    = 1'b0;
		pauseN    = 1'b1;
		hostZero  = 1'b0;
		hostOne   = 1'b0;
		modeThree = 1'b0;
		pauseSeen = 2'b00;
		holdAt    = -1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// One bit time: change data with the fall, sample two mclk after the rise.
	task automatic bit_time(input logic [1:0] drv, output logic [1:0] seen);
		@(posedge mclk);
		serClk   <= 1'b0;
		hostOne  <= drv[1];
		hostZero <= drv[0];
		tick(4);
		serClk <= 1'b1;
		tick(2);
		seen = {laneOneIn, laneZeroIn};
		tick(1);
	endtask

	task automatic byte_io(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
		logic [1:0] s;
		rx = 8'h00;
		for (int i = (dual ? 3 : 7); i >= 0; i--) begin
			if (dual) begin
				bit_time(tx[2 * i +: 2], s);
				rx[2 * i +: 2] = s;
			end else begin
				bit_time({1'b0, tx[i]}, s);
				rx[i] = s[1];
			end
		end
	endtask

	// Pause with the clock low, then wiggle the clock, which must be ignored.
	task automatic hold_pause();
		@(posedge mclk);
		serClk <= 1'b0;
		tick(4);
		pauseN <= 1'b0;
		tick(6);
		serClk <= 1'b1;
		tick(4);
		serClk    <= 1'b0;
		pauseSeen = {laneOneOeN, laneZeroOeN};
		tick(4);
		pauseN <= 1'b1;
		tick(4);
	endtask

	task automatic frame(input logic m3, input logic [7:0] op, input int na,
			input logic [23:0] a, input int nd, input logic [31:0] wr,
			input logic dual, output logic [31:0] rd);
		logic [7:0] b;
		rd        = 32'h00000000;
		modeThree = m3;
		@(posedge mclk);
		serClk <= m3;
		tick(4);
		chipSelN <= 1'b0;
		tick(3);
		byte_io(op, 1'b0, b);
		for (int k = 0; k < na; k++) begin
			byte_io(a[23 - 8 * k -: 8], 1'b0, b);
		end
		for (int k = 0; k < nd; k++) begin
			if (k == holdAt) begin
				hold_pause();
			end
			byte_io(wr[31 - 8 * k -: 8], dual, b);
			rd[31 - 8 * k -: 8] = b;
		end
		@(posedge mclk);
		serClk <= modeThree;
		tick(4);
		chipSelN <= 1'b1;
		hostZero <= ~hostZero;
		tick(6);
	endtask
endmodule

// ===== verif/sfpi_flash_if_test.sv
// Self-checking bench for the serial flash pin interface.
`timescale 1ns/1ps
module sfpi_flash_if_test;
	logic        mclk;
	logic        rst_b;
	logic        writeProtN;
	logic        chipSelN;
	logic        serClk;
	logic        laneZeroIn;
	logic        laneZeroOut;
	logic        laneZeroOeN;
	logic        laneOneIn;
	logic        laneOneOut;
	logic        laneOneOeN;
	logic        pauseN;
	logic        standby;
	logic        busy;
	logic        progFail;
	logic [31:0] rd;
	int          num_errors;
	int          total_checks;

	sfpi_flash_if #(.PROG_CYCLES(20)) dut (
		.mclk, .rst_b, .chipSelN, .serClk, .laneZeroIn, .laneZeroOut, .laneZeroOeN,
		.laneOneIn, .laneOneOut, .laneOneOeN, .writeProtN, .pauseN, .standby, .busy,
		.progFail
	);
	sfpi_host_model host (
		.mclk, .chipSelN, .serClk, .laneZeroIn, .laneOneIn, .pauseN, .laneZeroOut,
		.laneZeroOeN, .laneOneOut, .laneOneOeN
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Bounded wait, since a stuck engine must not hang the run.
	task automatic wait_done();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 40000) begin
			@(posedge mclk);
			n++;
		end
		check("busy end", busy, 1'b0);
		check("standby after work", standby, 1'b1);
	endtask

	task automatic read1(input logic [23:0] a, input logic [7:0] exp);
		host.frame(1'b0, sfpi_pkg::OP_READ, 3, a, 1, 32'h00000000, 1'b0, rd);
		check("read byte", rd[31:24], exp);
	endtask

	task automatic prog1(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
		host.frame(1'b0, op, 3, a, 1, {d, 24'h000000}, 1'b0, rd);
	endtask

	task automatic t_erase();
		logic [7:0] ops [3];
		ops = '{sfpi_pkg::OP_ERASE_PG, sfpi_pkg::OP_ERASE_4K, sfpi_pkg::OP_ERASE_32K};
		for (int i = 0; i < 3; i++) begin
			host.frame(i[0], ops[i], 3, 24'h001000, 0, 32'h00000000, 1'b0, rd);
			check("busy after erase", busy, 1'b1);
			check("standby while busy", standby, 1'b0);
			host.frame(1'b0, sfpi_pkg::OP_STATUS, 0, 24'h000000, 1, 32'h00000000, 1'b0, rd);
			check("status busy", rd[24], 1'b1);
			wait_done();
		end
	endtask

	task automatic t_program();
		host.frame(1'b0, sfpi_pkg::OP_PROG, 3, 24'h0010FF, 3, 32'hA53C9600, 1'b0, rd);
		check("busy after program", busy, 1'b1);
		wait_done();
		read1(24'h0010FF, 8'hA5);
		host.frame(1'b1, sfpi_pkg::OP_READ, 3, 24'h001000, 3, 32'h00000000, 1'b0, rd);
		check("page wrap mode three", rd[31:8], 24'h3C96FF);
		host.holdAt = 1;
		host.frame(1'b0, sfpi_pkg::OP_READ_DUAL, 3, 24'h001000, 2, 32'h00000000, 1'b1, rd);
		host.holdAt = -1;
		check("dual read", rd[31:16], 16'h3C96);
		check("pause floats", host.pauseSeen, 2'b11);
	endtask

	task automatic t_fail();
		prog1(sfpi_pkg::OP_PROG, 24'h001000, 8'hFF);
		check("fail flag", progFail, 1'b1);
		wait_done();
		host.frame(1'b0, sfpi_pkg::OP_STATUS, 0, 24'h000000, 1, 32'h00000000, 1'b0, rd);
		check("status fail", rd[29], 1'b1);
		host.frame(1'b0, sfpi_pkg::OP_ERASE_PG, 3, 24'h001000, 0, 32'h00000000, 1'b0, rd);
		check("fail cleared", progFail, 1'b0);
		wait_done();
		read1(24'h001000, 8'hFF);
	endtask

	task automatic t_protect();
		@(posedge mclk);
		writeProtN <= 1'b0;
		prog1(sfpi_pkg::OP_PROG, 24'h001000, 8'h00);
		check("busy under protect", busy, 1'b0);
		read1(24'h001000, 8'hFF);
		@(posedge mclk);
		writeProtN <= 1'b1;
		prog1(sfpi_pkg::OP_OTP_PROG, 24'h000000, 8'h00);
		check("factory area locked", progFail, 1'b1);
		wait_done();
		prog1(sfpi_pkg::OP_OTP_PROG, 24'h000040, 8'h00);
		check("user area locked", progFail, 1'b1);
		wait_done();
	endtask

	// Two-lane write: lane one must land in the upper bit of every pair.
	task automatic t_dual_prog();
		host.frame(1'b0, sfpi_pkg::OP_PROG_DUAL, 3, 24'h001010, 2, 32'h5AC30000, 1'b1, rd);
		check("dual program fail", progFail, 1'b0);
		wait_done();
		host.frame(1'b0, sfpi_pkg::OP_READ, 3, 24'h001010, 2, 32'h00000000, 1'b0, rd);
		check("dual program data", rd[31:16], 16'h5AC3);
	endtask

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		rst_b      = 1'b0;
		writeProtN = 1'b1;
		repeat (8) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		check("reset standby", standby, 1'b1);
		check("reset enables", {laneOneOeN, laneZeroOeN}, 2'b11);
		check("reset fail", progFail, 1'b0);
		t_erase();
		t_program();
		t_fail();
		t_dual_prog();
		t_protect();
		report_and_stop();
	end

	initial begin
		repeat (80000) @(posedge mclk);
		num_errors++;
		report_and_stop();
	end
endmodule
